/* hw/alm_pkg.sv */
// Constants and types shared by the layer-4 rule entry block
package alm_pkg;
	// ==========================================================
	// Direct register addresses
	localparam logic [7:0] ADDR_TBL_CTRL = 8'h6e;
	localparam logic [7:0] ADDR_OFFSET = 8'h6f;
	localparam logic [7:0] ADDR_DATA = 8'ha0;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] OFFSET_RST = 8'h00;
	// ==========================================================
	// Table-control fields
	localparam int TBL_SEL_MSB = 7;
	localparam int TBL_SEL_LSB = 5;
	localparam logic [2:0] TBL_SEL_RULE = 3'b010;
	localparam int PORT_MSB = 3;
	localparam logic [3:0] PORT_FIRST = 4'h1;
	localparam logic [3:0] PORT_LAST = 4'h5;
	localparam int NUM_PORTS = 5;
	// ==========================================================
	// Entry byte offsets
	localparam logic [7:0] OFS_LOWER_HI = 8'h00;
	localparam logic [7:0] OFS_UPPER_LO = 8'h01;
	localparam logic [7:0] OFS_UPPER_HI = 8'h02;
	localparam logic [7:0] OFS_LOWER_LO = 8'h03;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_PROTO = 8'h05;
	localparam logic [7:0] OFS_MASK = 8'h06;
	localparam logic [7:0] OFS_FLAG = 8'h07;
	localparam logic [7:0] OFS_SPARE_A = 8'h08;
	localparam logic [7:0] OFS_SPARE_B = 8'h09;
	localparam int STORED_BYTES = 8;
	localparam logic [7:0] ENTRY_RST = 8'h00;
	// ==========================================================
	// Field positions inside entry bytes
	localparam int MODE_MSB = 2;
	localparam int MODE_LSB = 1;
	localparam int PROTO_TOP_BIT = 0;
	localparam int PROTO_LOW_MSB = 7;
	localparam int PROTO_LOW_LSB = 1;
	localparam int FLAG_EN_BIT = 0;
	// ==========================================================
	// Port compare modes
	localparam logic [1:0] CMP_OFF = 2'h0;
	localparam logic [1:0] CMP_EITHER = 2'h1;
	localparam logic [1:0] CMP_INSIDE = 2'h2;
	localparam logic [1:0] CMP_OUTSIDE = 2'h3;
	typedef logic [7:0] alm_byte_t;
endpackage : alm_pkg

/* hw/alm_entry_if.sv */
// Entry fields and packet values passed to the match evaluator
`timescale 1ns/1ps
`default_nettype none
interface alm_entry_if;
	logic [15:0] lower;
	logic [15:0] upper;
	logic [1:0] port_compare_mode;
	logic [7:0] ip_protocol_value;
	logic tcp_control_match_enable;
	logic [7:0] tcp_control_bits_mask;
	logic [7:0] flag_pattern;
	logic [15:0] pkt_value;
	logic [7:0] pkt_proto;
	logic [7:0] pkt_flags;
	logic hit;
	modport store (output lower, upper, port_compare_mode, ip_protocol_value,
		tcp_control_match_enable, tcp_control_bits_mask, flag_pattern,
		pkt_value, pkt_proto, pkt_flags, input hit);
	modport eval (input lower, upper, port_compare_mode, ip_protocol_value,
		tcp_control_match_enable, tcp_control_bits_mask, flag_pattern,
		pkt_value, pkt_proto, pkt_flags, output hit);
endinterface : alm_entry_if
`default_nettype wire

/* hw/alm_match.sv */
// Layer-4 match evaluator for one rule entry
`timescale 1ns/1ps
`default_nettype none
module alm_match (
	alm_entry_if.eval ent
);
	import alm_pkg::*;

	logic cmp_ok;
	logic in_range;
	logic flag_ok;

	always_comb begin
		in_range = (ent.pkt_value >= ent.lower) && (ent.pkt_value <= ent.upper);
		unique case (ent.port_compare_mode)
			CMP_OFF: cmp_ok = 1'b1; // R5
			CMP_EITHER: cmp_ok = (ent.pkt_value == ent.lower) ||
				(ent.pkt_value == ent.upper); // R5
			CMP_INSIDE: cmp_ok = in_range; // R5
			CMP_OUTSIDE: cmp_ok = !in_range; // R5
		endcase
		// Flags only count when enabled
		flag_ok = !ent.tcp_control_match_enable ||
			((ent.pkt_flags & ent.tcp_control_bits_mask) ==
			(ent.flag_pattern & ent.tcp_control_bits_mask)); // R7 R14
		ent.hit = cmp_ok && flag_ok &&
			(ent.pkt_proto == ent.ip_protocol_value);
	end
endmodule : alm_match
`default_nettype wire

/* hw/alm_top.sv */
// Layer-4 rule entry store with indirect access and match result
`timescale 1ns/1ps
`default_nettype none
// Contract
// (R1) Writing 010 into bits 7:5 of the table-control register selects the rule table for indirect transfers.
// (R2) Bits 3:0 of the table-control register name the switch port, one to five, whose entry is reached.
// (R3) The offset register picks one entry byte, which moves through the data window register.
// (R4) Entry byte 0x03 holds the low byte of the lower range bound.
// (R5) Bits 2:1 of byte 0x04 set compare mode: off, equal to either bound, inside, or outside the bounds.
// (R6) The protocol value is bit 0 of byte 0x04 on top of bits 7:1 of byte 0x05.
// (R7) Bit 0 of byte 0x05 switches flag matching into the match decision.
// (R8) Entry byte 0x06 holds the mask of flag bits that take part.
// (R9) Entry byte 0x07 holds the flag pattern compared against the packet flags.
// (R10) Entry byte 0x08 is reserved, read-only and reads zero.
// (R11) Entry byte 0x09 is reserved, read-only and reads zero.
// (R12) Software keeps each layer's criteria together in an entry of their own.
// (R13) Entry byte 0x02 holds the high byte of the upper range bound.
// (R14) Enabled flag matching passes only when masked packet flags equal the masked pattern.
// (R15) All writable entry fields reset to zero, leaving comparisons disabled; the protocol compare stays on and hits only protocol zero.
module alm_top (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire alm_pkg::alm_byte_t reg_wdata,
	output alm_pkg::alm_byte_t reg_rdata,
	output logic reg_rvalid,
	// Packet to classify
	input wire logic pkt_valid,
	input wire logic [3:0] pkt_port,
	input wire logic [7:0] pkt_proto,
	input wire logic [15:0] pkt_l4_value,
	input wire logic [7:0] pkt_tcp_flags,
	// Match result
	output logic match_valid,
	output logic match_hit
);
	import alm_pkg::*;

	// ==========================================================
	// Decode helpers
	function automatic logic port_ok(input logic [3:0] p);
		return (p >= PORT_FIRST) && (p <= PORT_LAST);
	endfunction : port_ok

	function automatic logic [2:0] port_idx(input logic [3:0] p);
		logic [3:0] d;
		d = p - PORT_FIRST;
		return d[2:0];
	endfunction : port_idx

	// ==========================================================
	// Control, offset and entry storage
	alm_byte_t ctrl_r;
	alm_byte_t offset_r;
	alm_byte_t entry_r [NUM_PORTS][STORED_BYTES];
	logic win_sel;
	logic [2:0] win_port;
	alm_byte_t win_byte;

	always_comb begin
		win_sel = (ctrl_r[TBL_SEL_MSB:TBL_SEL_LSB] == TBL_SEL_RULE) &&
			port_ok(ctrl_r[PORT_MSB:0]); // R1 R2
		win_port = port_idx(ctrl_r[PORT_MSB:0]);
		win_byte = 8'h00;
		// Spare bytes 0x08, 0x09 and beyond fall through as zero
		if (win_sel && offset_r < OFS_SPARE_A) begin
			win_byte = entry_r[win_port][offset_r[2:0]]; // R3 R10 R11
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= CTRL_RST;
			offset_r <= OFFSET_RST;
		end else if (ce && reg_wr) begin
			if (reg_addr == ADDR_TBL_CTRL) begin
				ctrl_r <= reg_wdata; // R1 R2
			end
			if (reg_addr == ADDR_OFFSET) begin
				offset_r <= reg_wdata; // R3
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				for (int b = 0; b < STORED_BYTES; b++) begin
					entry_r[p][b] <= ENTRY_RST; // R15
				end
			end
		end else if (ce && reg_wr && reg_addr == ADDR_DATA && win_sel &&
				offset_r < OFS_SPARE_A) begin
			entry_r[win_port][offset_r[2:0]] <= reg_wdata; // R3 R4 R8 R9 R13
		end
	end

	// ==========================================================
	// Register read path
	alm_byte_t rd_mux;

	always_comb begin
		unique case (reg_addr)
			ADDR_TBL_CTRL: rd_mux = ctrl_r;
			ADDR_OFFSET: rd_mux = offset_r;
			ADDR_DATA: rd_mux = win_byte;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else if (ce) begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rd_mux; // R3
			end
		end
	end

	// ==========================================================
	// Field extraction for the packet's ingress port
	alm_entry_if ent ();
	logic [2:0] pi;

	always_comb begin
		pi = port_idx(pkt_port);
		if (!port_ok(pkt_port)) begin
			pi = 3'h0;
		end
		ent.lower = {entry_r[pi][OFS_LOWER_HI[2:0]],
			entry_r[pi][OFS_LOWER_LO[2:0]]}; // R4
		ent.upper = {entry_r[pi][OFS_UPPER_HI[2:0]],
			entry_r[pi][OFS_UPPER_LO[2:0]]}; // R13
		ent.port_compare_mode = entry_r[pi][OFS_MODE[2:0]][MODE_MSB:MODE_LSB];
		ent.ip_protocol_value = {entry_r[pi][OFS_MODE[2:0]][PROTO_TOP_BIT],
			entry_r[pi][OFS_PROTO[2:0]][PROTO_LOW_MSB:PROTO_LOW_LSB]}; // R6
		ent.tcp_control_match_enable =
			entry_r[pi][OFS_PROTO[2:0]][FLAG_EN_BIT]; // R7
		ent.tcp_control_bits_mask = entry_r[pi][OFS_MASK[2:0]]; // R8
		ent.flag_pattern = entry_r[pi][OFS_FLAG[2:0]]; // R9
		ent.pkt_value = pkt_l4_value;
		ent.pkt_proto = pkt_proto;
		ent.pkt_flags = pkt_tcp_flags;
	end

	alm_match u_match (
		.ent(ent.eval)
	);

	// Registered so the result never glitches with entry writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			match_valid <= 1'b0;
			match_hit <= 1'b0;
		end else if (ce) begin
			match_valid <= pkt_valid;
			match_hit <= pkt_valid && port_ok(pkt_port) && ent.hit;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_ctrl_write_lands: assert property ( // R1
		ce && reg_wr && reg_addr == ADDR_TBL_CTRL |=>
		ctrl_r == $past(reg_wdata))
		else $error("table control not stored");
	a_window_bad_port: assert property ( // R2
		ce && reg_rd && reg_addr == ADDR_DATA &&
		!port_ok(ctrl_r[PORT_MSB:0]) |=> reg_rvalid && reg_rdata == 8'h00)
		else $error("window read with bad port not zero");
	a_window_roundtrip: assert property ( // R3
		ce && reg_wr && reg_addr == ADDR_DATA && win_sel &&
		offset_r < OFS_SPARE_A ##1 ce && reg_rd && reg_addr == ADDR_DATA
		&& !reg_wr && $stable(ctrl_r) && $stable(offset_r) |=>
		reg_rdata == $past(reg_wdata, 2))
		else $error("window byte did not read back");
	a_spare_zero: assert property ( // R10
		ce && reg_rd && reg_addr == ADDR_DATA &&
		(offset_r == OFS_SPARE_A || offset_r == OFS_SPARE_B) |=>
		reg_rdata == 8'h00)
		else $error("spare entry byte not zero");
	a_mode_off_hit: assert property ( // R5
		ce && pkt_valid && port_ok(pkt_port) &&
		ent.port_compare_mode == CMP_OFF && !ent.tcp_control_match_enable &&
		pkt_proto == ent.ip_protocol_value |=> match_hit)
		else $error("disabled compare blocked a match");
	a_proto_miss: assert property ( // R6
		ce && pkt_valid && pkt_proto != ent.ip_protocol_value |=> !match_hit)
		else $error("protocol mismatch matched");
	a_flag_miss: assert property ( // R14
		ce && pkt_valid && ent.tcp_control_match_enable &&
		((pkt_tcp_flags ^ ent.flag_pattern) & ent.tcp_control_bits_mask)
		!= 8'h00 |=> !match_hit)
		else $error("masked flag mismatch matched");
	a_inside_miss: assert property ( // R5
		ce && pkt_valid && ent.port_compare_mode == CMP_INSIDE &&
		(pkt_l4_value < ent.lower || pkt_l4_value > ent.upper) |=> !match_hit)
		else $error("out of range value matched inside mode");
	a_outside_miss: assert property ( // R5
		ce && pkt_valid && ent.port_compare_mode == CMP_OUTSIDE &&
		pkt_l4_value >= ent.lower && pkt_l4_value <= ent.upper |=> !match_hit)
		else $error("in range value matched outside mode");
	a_read_pulse: assert property (
		ce && !reg_rd |=> !reg_rvalid)
		else $error("read valid without read");
	// A frozen cycle must leave every registered output alone
	a_frozen_hold: assert property (
		!ce |=> $stable(reg_rdata) && $stable(reg_rvalid) &&
		$stable(match_valid) && $stable(match_hit))
		else $error("outputs moved while frozen");
	a_either_hit: assert property ( // R5
		ce && pkt_valid && port_ok(pkt_port) &&
		ent.port_compare_mode == CMP_EITHER &&
		!ent.tcp_control_match_enable &&
		pkt_proto == ent.ip_protocol_value &&
		pkt_l4_value == ent.upper |=> match_hit)
		else $error("value on a bound missed in either mode");
endmodule : alm_top
`default_nettype wire

/* dv/alm_top_tb.sv */
// Self-checking bench for the layer-4 rule entry block
`timescale 1ns/1ps
`default_nettype none
module alm_top_tb;
	import alm_pkg::*;
	logic clk, rst_n, ce, reg_wr, reg_rd, pkt_valid;
	logic [7:0] reg_addr, pkt_proto, pkt_tcp_flags;
	alm_byte_t reg_wdata, reg_rdata;
	logic reg_rvalid, match_valid, match_hit;
	logic [3:0] pkt_port;
	logic [15:0] pkt_l4_value;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [15:0] vals [5] = '{16'h00ff, 16'h0100, 16'h0150, 16'h0200, 16'h0201};
	logic [4:0] hits [4] = '{5'b11111, 5'b01010, 5'b01110, 5'b10001};
	alm_top dut (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.pkt_valid(pkt_valid), .pkt_port(pkt_port), .pkt_proto(pkt_proto),
		.pkt_l4_value(pkt_l4_value), .pkt_tcp_flags(pkt_tcp_flags),
		.match_valid(match_valid), .match_hit(match_hit));
	// ==========================================================
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_total++;
			end_sim();
		end
	end
	// ==========================================================
	// Compare and access tasks
	task automatic end_sim();
		if (err_total == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim
	task automatic chk_byte(input alm_byte_t got, input alm_byte_t exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit
	// Called at a falling edge; strobe stays up until the next access or idle
	task automatic acc(input logic w, input logic [7:0] a, input alm_byte_t d);
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
	endtask : acc
	task automatic idle();
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		pkt_valid = 1'b0;
		@(negedge clk);
	endtask : idle
	task automatic rd(input logic [7:0] a, input alm_byte_t e);
		acc(1'b0, a, 8'h00);
		chk_bit(reg_rvalid, 1'b1);
		chk_byte(reg_rdata, e);
	endtask : rd
	task automatic sel(input logic [3:0] p, input logic [7:0] o);
		acc(1'b1, ADDR_TBL_CTRL, {TBL_SEL_RULE, 1'b0, p});
		acc(1'b1, ADDR_OFFSET, o);
	endtask : sel
	task automatic wb(input logic [3:0] p, input logic [7:0] o, input alm_byte_t d);
		sel(p, o);
		acc(1'b1, ADDR_DATA, d);
	endtask : wb
	task automatic rb(input logic [3:0] p, input logic [7:0] o, input alm_byte_t e);
		sel(p, o);
		rd(ADDR_DATA, e);
	endtask : rb
	task automatic cfg(input logic [3:0] p, input logic [15:0] lo, hi,
		input logic [1:0] m, input logic [7:0] pr, input logic fe,
		input logic [7:0] mk, pt);
		wb(p, 8'h00, lo[15:8]);
		wb(p, 8'h01, hi[7:0]);
		wb(p, 8'h02, hi[15:8]);
		wb(p, 8'h03, lo[7:0]);
		wb(p, 8'h04, {5'h00, m, pr[7]});
		wb(p, 8'h05, {pr[6:0], fe});
		wb(p, 8'h06, mk);
		wb(p, 8'h07, pt);
	endtask : cfg
	task automatic pk(input logic [3:0] p, input logic [7:0] pr,
		input logic [15:0] v, input logic [7:0] fl, input logic e);
		pkt_valid = 1'b1;
		pkt_port = p;
		pkt_proto = pr;
		pkt_l4_value = v;
		pkt_tcp_flags = fl;
		@(negedge clk);
		chk_bit(match_valid, 1'b1);
		chk_bit(match_hit, e);
	endtask : pk
	// ==========================================================
	// Test sequence
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		pkt_valid = 1'b0;
		pkt_port = 4'h0;
		pkt_proto = 8'h00;
		pkt_l4_value = 16'h0000;
		pkt_tcp_flags = 8'h00;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		pk(4'h1, 8'h00, 16'h1234, 8'hff, 1'b1);
		for (int o = 0; o < 10; o++) rb(4'h1, o[7:0], 8'h00);
		for (int o = 0; o < 10; o++) wb(4'h2, o[7:0], 8'(8'h11 * (o + 1)));
		for (int o = 0; o < 10; o++) rb(4'h2, o[7:0], o < 8 ? 8'(8'h11 * (o + 1)) : 8'h00);
		rb(4'h4, 8'h03, 8'h00);
		wb(4'h6, 8'h03, 8'hff);
		rb(4'h6, 8'h03, 8'h00);
		// Wrong table code: data window must stay inert
		acc(1'b1, ADDR_TBL_CTRL, 8'h22);
		acc(1'b1, ADDR_DATA, 8'h00);
		rd(ADDR_DATA, 8'h00);
		rd(ADDR_TBL_CTRL, 8'h22);
		rb(4'h2, 8'h03, 8'h44);
		acc(1'b1, 8'h55, 8'hff);
		rd(8'h55, 8'h00);
		// Frozen cycle must not move the offset
		sel(4'h2, 8'h03);
		ce = 1'b0;
		acc(1'b1, ADDR_OFFSET, 8'h07);
		ce = 1'b1;
		rd(ADDR_DATA, 8'h44);
		// Read straight after the write, no reselect between
		wb(4'h5, 8'h07, 8'h3c);
		rd(ADDR_DATA, 8'h3c);
		for (int m = 0; m < 4; m++) begin
			cfg(4'h3, 16'h0100, 16'h0200, m[1:0], 8'h86, 1'b0, 8'h00, 8'h00);
			for (int i = 0; i < 5; i++) pk(4'h3, 8'h86, vals[i], 8'h00, hits[m][i]);
		end
		pk(4'h3, 8'h06, 16'h0000, 8'h00, 1'b0);
		pk(4'h3, 8'h87, 16'h0000, 8'h00, 1'b0);
		pk(4'h7, 8'h00, 16'h0000, 8'h00, 1'b0);
		cfg(4'h3, 16'h0100, 16'h0200, CMP_OFF, 8'h86, 1'b1, 8'h12, 8'h32);
		pk(4'h3, 8'h86, 16'h0000, 8'h13, 1'b1);
		pk(4'h3, 8'h86, 16'h0000, 8'h02, 1'b0);
		pk(4'h3, 8'h86, 16'h0000, 8'hed, 1'b0);
		cfg(4'h3, 16'h0100, 16'h0200, CMP_OFF, 8'h86, 1'b0, 8'h12, 8'h32);
		pk(4'h3, 8'h86, 16'h0000, 8'h00, 1'b1);
		// Second reset in mid-run
		idle();
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		rd(ADDR_TBL_CTRL, CTRL_RST);
		rd(ADDR_OFFSET, OFFSET_RST);
		rb(4'h2, 8'h06, 8'h00);
		rd(ADDR_OFFSET, 8'h06);
		end_sim();
	end
endmodule : alm_top_tb
`default_nettype wire
